//--- rtl/dpms_defs.vh
// constants for the display port mode-set sequencer port logic
// Functional notes
// - after transcoder enable clears, off status is reported within two frame times.
// - buffer, training control and FEC disable; buffer reports idle within 8 us.
// - IO power request reports enabled within 20 us.
// - enabled port buffer reports not idle (0b) within 500 us.
`ifndef DPMS_DEFS_VH
`define DPMS_DEFS_VH

`define DPMS_CLK_MHZ          50
// ----------------------------------------------------------------------------
// timing limits and the settle times this logic actually uses
// ----------------------------------------------------------------------------
`define DPMS_IO_PWR_LIMIT_US  20
`define DPMS_BUF_WAKE_LIMIT_US 500
`define DPMS_BUF_IDLE_LIMIT_US 8
`define DPMS_IO_PWR_US        10
`define DPMS_BUF_WAKE_US      2
`define DPMS_BUF_IDLE_US      4
`define DPMS_IO_PWR_CYC       (`DPMS_IO_PWR_US * `DPMS_CLK_MHZ)
`define DPMS_BUF_WAKE_CYC     (`DPMS_BUF_WAKE_US * `DPMS_CLK_MHZ)
`define DPMS_BUF_IDLE_CYC     (`DPMS_BUF_IDLE_US * `DPMS_CLK_MHZ)
`define DPMS_TMR_W            12

// ----------------------------------------------------------------------------
// training pattern selection and symbol kinds driven to the lanes
// ----------------------------------------------------------------------------
`define DPMS_TP_PAT1          2'h0
`define DPMS_TP_IDLE          2'h1
`define DPMS_TP_NORMAL        2'h2
`define DPMS_SYM_OFF          2'h0
`define DPMS_SYM_PAT1         2'h1
`define DPMS_SYM_IDLE         2'h2
`define DPMS_SYM_NORMAL       2'h3
`define DPMS_MIN_IDLES        3'h5
`define DPMS_VGA_SCREEN_OFF   5
`endif

//--- rtl/dpms_port_ctrl.v
// port-side logic: transcoder on/off, IO power, port buffer, training pattern, FEC
`include "dpms_defs.vh"
module dpms_port_ctrl
(
    // clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // transcoder control and frame timing
    input  wire        transcoder_enable,
    input  wire        frame_start,
    // power and buffer control
    input  wire        io_power_request,
    input  wire        port_buffer_enable,
    // link training control
    input  wire        link_training_enable,
    input  wire [1:0]  link_training_select,
    input  wire        idle_pattern_tick,
    input  wire        fec_enable,
    // legacy vga
    input  wire        vga_plane_active,
    input  wire [7:0]  vga_clocking_mode_register,
    // status
    output reg         transcoder_active_q,
    output reg         io_power_enabled_q,
    output reg         port_buffer_idle_q,
    output reg         min_idles_sent_q,
    output reg         fec_active_q,
    output reg  [1:0]  lane_symbol_kind_q,
    output reg         vga_screen_blank_q
);
    // ------------------------------------------------------------------------
    // buffer state machine
    // ------------------------------------------------------------------------
    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_WAKE  = 4'h2;
    localparam [3:0] ST_ON    = 4'h4;
    localparam [3:0] ST_DRAIN = 4'h8;

    // settle counts are worked out as integers, then cut to the timer width on purpose
    localparam integer           IO_PWR_CYC    = `DPMS_IO_PWR_CYC;
    localparam integer           BUF_WAKE_CYC  = `DPMS_BUF_WAKE_CYC;
    localparam integer           BUF_IDLE_CYC  = `DPMS_BUF_IDLE_CYC;
    localparam [`DPMS_TMR_W-1:0] IO_PWR_LOAD   = IO_PWR_CYC[`DPMS_TMR_W-1:0];
    localparam [`DPMS_TMR_W-1:0] BUF_WAKE_LOAD = BUF_WAKE_CYC[`DPMS_TMR_W-1:0];
    localparam [`DPMS_TMR_W-1:0] BUF_IDLE_LOAD = BUF_IDLE_CYC[`DPMS_TMR_W-1:0];

    reg  [3:0] st_q;
    reg  [3:0] st_d;
    reg        io_req_q;
    reg  [2:0] idle_cnt_q;
    reg  [1:0] sym_d;
    wire       io_start;
    wire       io_done;
    wire       buf_start;
    wire       buf_load_sel;
    wire       buf_done;
    wire [`DPMS_TMR_W-1:0] buf_load;

    // maps the training control fields onto the symbol kind the lanes carry
    function [1:0] sym_for;
        input       en;
        input [1:0] sel;
        begin
            if (!en)
                sym_for = `DPMS_SYM_OFF;
            else if (sel == `DPMS_TP_IDLE)
                sym_for = `DPMS_SYM_IDLE;
            else if (sel == `DPMS_TP_NORMAL)
                sym_for = `DPMS_SYM_NORMAL;
            else
                sym_for = `DPMS_SYM_PAT1;
        end
    endfunction

    // ------------------------------------------------------------------------
    // transcoder: changes state only on a frame boundary
    // ------------------------------------------------------------------------
    // turning off at the next frame start keeps the off status within one frame
    always @(posedge clock)
    begin
        if (!rst_n)
            transcoder_active_q <= 1'b0;
        else if (frame_start)
            transcoder_active_q <= transcoder_enable;
    end

    // ------------------------------------------------------------------------
    // IO power
    // ------------------------------------------------------------------------
    // a request that drops before the settle time cancels the count; it must rise again
    assign io_start = io_power_request && !io_req_q;

    dpms_timer u_io_tmr
    (
        .clock  (clock),
        .rst_n  (rst_n),
        .start  (io_start),
        .cancel (!io_power_request),
        .load   (IO_PWR_LOAD),
        // done alone ends each wait, so busy is left open
        .busy   (),
        .done   (io_done)
    );

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            io_req_q           <= 1'b0;
            io_power_enabled_q <= 1'b0;
        end
        else
        begin
            io_req_q <= io_power_request;
            // dropping the request removes power at once; no settle needed
            if (!io_power_request)
                io_power_enabled_q <= 1'b0;
            else if (io_done)
                io_power_enabled_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // port buffer
    // ------------------------------------------------------------------------
    // wake needs lane power; an enable without IO power waits for it
    assign buf_start    = ((st_q == ST_IDLE) && port_buffer_enable && io_power_enabled_q) ||
                          ((st_q == ST_WAKE || st_q == ST_ON) && !port_buffer_enable);
    assign buf_load_sel = (st_q == ST_IDLE);
    assign buf_load     = buf_load_sel ? BUF_WAKE_LOAD : BUF_IDLE_LOAD;

    dpms_timer u_buf_tmr
    (
        .clock  (clock),
        .rst_n  (rst_n),
        .start  (buf_start),
        .cancel (1'b0),
        .load   (buf_load),
        .busy   (),
        .done   (buf_done)
    );

    // a disable during wake drains at once, so the lanes never see a half-woken buffer
    always @*
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:
                if (buf_start)
                    st_d = ST_WAKE;
            ST_WAKE:
                if (!port_buffer_enable)
                    st_d = ST_DRAIN;
                else if (buf_done)
                    st_d = ST_ON;
            ST_ON:
                if (!port_buffer_enable)
                    st_d = ST_DRAIN;
            ST_DRAIN:
                if (buf_done)
                    st_d = ST_IDLE;
            default:
                st_d = ST_IDLE;
        endcase
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            st_q               <= ST_IDLE;
            port_buffer_idle_q <= 1'b1;
        end
        else
        begin
            st_q               <= st_d;
            port_buffer_idle_q <= (st_d == ST_IDLE) || (st_d == ST_WAKE);
        end
    end

    // ------------------------------------------------------------------------
    // training pattern, idle count and FEC
    // ------------------------------------------------------------------------
    // a disabled training control goes straight to off, never through idle
    always @*
    begin
        sym_d = `DPMS_SYM_OFF;
        if (st_q == ST_ON)
            sym_d = sym_for(link_training_enable, link_training_select);
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            lane_symbol_kind_q <= `DPMS_SYM_OFF;
            idle_cnt_q         <= 3'h0;
            min_idles_sent_q   <= 1'b0;
            fec_active_q       <= 1'b0;
            vga_screen_blank_q <= 1'b0;
        end
        else
        begin
            lane_symbol_kind_q <= sym_d;
            // the count restarts whenever the lanes leave idle, so an old count never carries over
            if (lane_symbol_kind_q != `DPMS_SYM_IDLE)
            begin
                idle_cnt_q       <= 3'h0;
                min_idles_sent_q <= 1'b0;
            end
            else if (idle_pattern_tick && !min_idles_sent_q)
            begin
                idle_cnt_q <= idle_cnt_q + 3'h1;
                if (idle_cnt_q + 3'h1 == `DPMS_MIN_IDLES)
                    min_idles_sent_q <= 1'b1;
            end
            fec_active_q       <= fec_enable && (st_q == ST_ON);
            vga_screen_blank_q <= vga_plane_active &&
                                  vga_clocking_mode_register[`DPMS_VGA_SCREEN_OFF];
        end
    end
endmodule // dpms_port_ctrl

//--- rtl/dpms_timer.v
// one-shot down counter used for the power and buffer settle delays
`include "dpms_defs.vh"
module dpms_timer
(
    // clock and reset
    input  wire                     clock,
    input  wire                     rst_n,
    // control
    input  wire                     start,
    input  wire                     cancel,
    input  wire [`DPMS_TMR_W-1:0]   load,
    // status
    output wire                     busy,
    output wire                     done
);
    reg [`DPMS_TMR_W-1:0] cnt_q;
    reg                   busy_q;

    assign busy = busy_q;
    assign done = busy_q && (cnt_q == {{(`DPMS_TMR_W-1){1'b0}}, 1'b1});

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            cnt_q  <= {`DPMS_TMR_W{1'b0}};
            busy_q <= 1'b0;
        end
        else if (start)
        begin
            cnt_q  <= load;
            busy_q <= 1'b1;
        end
        else if (cancel || done)
        begin
            busy_q <= 1'b0;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - {{(`DPMS_TMR_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // dpms_timer

//--- sim/dpms_port_ctrl_checker.sv
// concurrent checks on the port control block's status outputs
`include "dpms_defs.vh"
module dpms_port_ctrl_checker
(
    // clock and reset
    input logic       clock,
    input logic       rst_n,
    // controls
    input logic       transcoder_enable,
    input logic       frame_start,
    input logic       io_power_request,
    input logic       port_buffer_enable,
    input logic       idle_pattern_tick,
    input logic       fec_enable,
    input logic       vga_plane_active,
    input logic [7:0] vga_clocking_mode_register,
    // status
    input logic       transcoder_active_q,
    input logic       io_power_enabled_q,
    input logic       port_buffer_idle_q,
    input logic       min_idles_sent_q,
    input logic       fec_active_q,
    input logic       vga_screen_blank_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_frame_take: assert property (frame_start |=> transcoder_active_q == $past(transcoder_enable))
        else $error("transcoder state not taken at frame start");
    a_frame_hold: assert property (!frame_start |=> $stable(transcoder_active_q))
        else $error("transcoder state moved between frames");
    a_io_pwr_time: assert property ($rose(io_power_request) |-> ##[1:1000] (io_power_enabled_q || !io_power_request))
        else $error("io power not enabled in time");
    a_io_pwr_drop: assert property (!io_power_request |=> !io_power_enabled_q)
        else $error("io power enabled without request");
    a_buf_wake_time: assert property ($rose(port_buffer_enable) && io_power_enabled_q && port_buffer_idle_q
        |-> ##[1:1000] (!port_buffer_idle_q || !port_buffer_enable))
        else $error("buffer did not leave idle in time");
    a_buf_drain_time: assert property ($fell(port_buffer_enable) |-> ##[1:400] (port_buffer_idle_q || port_buffer_enable))
        else $error("buffer did not return to idle in time");
    a_fec_cause: assert property (fec_active_q |-> $past(fec_enable))
        else $error("fec active without enable");
    a_idles_cause: assert property ($rose(min_idles_sent_q) |-> $past(idle_pattern_tick))
        else $error("idle count rose without a tick");
    a_vga_blank: assert property ($past(rst_n) |-> vga_screen_blank_q == ($past(vga_plane_active)
        && $past(vga_clocking_mode_register[`DPMS_VGA_SCREEN_OFF])))
        else $error("screen blank does not follow bit 5");
    c_buf_wake: cover property ($fell(port_buffer_idle_q));
    c_idles: cover property ($rose(min_idles_sent_q));
    c_io_pwr: cover property ($rose(io_power_enabled_q));
endmodule // dpms_port_ctrl_checker

bind dpms_port_ctrl dpms_port_ctrl_checker i_dpms_port_ctrl_checker (.clock(clock), .rst_n(rst_n),
    .transcoder_enable(transcoder_enable), .frame_start(frame_start), .io_power_request(io_power_request),
    .port_buffer_enable(port_buffer_enable), .idle_pattern_tick(idle_pattern_tick), .fec_enable(fec_enable),
    .vga_plane_active(vga_plane_active), .vga_clocking_mode_register(vga_clocking_mode_register),
    .transcoder_active_q(transcoder_active_q), .io_power_enabled_q(io_power_enabled_q),
    .port_buffer_idle_q(port_buffer_idle_q), .min_idles_sent_q(min_idles_sent_q),
    .fec_active_q(fec_active_q), .vga_screen_blank_q(vga_screen_blank_q));

//--- sim/dpms_port_ctrl_tb.sv
// self-checking bench for the port control block
`include "dpms_defs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module dpms_port_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clock = 0, rst_n = 0, transcoder_enable = 0, frame_start = 0, io_power_request = 0;
    logic       port_buffer_enable = 0, link_training_enable = 0, fec_enable = 0, vga_plane_active = 0;
    logic [1:0] link_training_select = 2'h0, lane_symbol_kind_q;
    logic [7:0] vga_clocking_mode_register = 8'h00;
    logic       idle_pattern_tick, transcoder_active_q, io_power_enabled_q, port_buffer_idle_q;
    logic       min_idles_sent_q, fec_active_q, vga_screen_blank_q;
    int         mismatches = 0, checks = 0, n;
    logic [7:0] status;
    assign status = {transcoder_active_q, io_power_enabled_q, port_buffer_idle_q, min_idles_sent_q,
                     fec_active_q, lane_symbol_kind_q, vga_screen_blank_q};
    // rows: {enable, select, vga active, bit 5} -> {symbol kind, blank}
    logic [4:0] row_in [5]  = '{5'h13, 5'h16, 5'h19, 5'h1c, 5'h0b};
    logic [2:0] row_out [5] = '{3'h3, 3'h4, 3'h6, 3'h2, 3'h1};
    always #10 clock = ~clock;
    dpms_port_ctrl i_dpms_port_ctrl (.clock(clock), .rst_n(rst_n), .transcoder_enable(transcoder_enable),
        .frame_start(frame_start), .io_power_request(io_power_request), .port_buffer_enable(port_buffer_enable),
        .link_training_enable(link_training_enable), .link_training_select(link_training_select),
        .idle_pattern_tick(idle_pattern_tick), .fec_enable(fec_enable), .vga_plane_active(vga_plane_active),
        .vga_clocking_mode_register(vga_clocking_mode_register), .transcoder_active_q(transcoder_active_q),
        .io_power_enabled_q(io_power_enabled_q), .port_buffer_idle_q(port_buffer_idle_q),
        .min_idles_sent_q(min_idles_sent_q), .fec_active_q(fec_active_q),
        .lane_symbol_kind_q(lane_symbol_kind_q), .vga_screen_blank_q(vga_screen_blank_q));
    dpms_sink_model i_dpms_sink_model (.clock(clock), .lane_symbol_kind_q(lane_symbol_kind_q),
        .idle_pattern_tick(idle_pattern_tick));
    task complete_run;
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task frame;
        @(negedge clock) frame_start = 1'b1;
        @(negedge clock) frame_start = 1'b0;
        @(negedge clock);
    endtask
    // generous limit: the whole run needs under two thousand cycles
    initial
    begin
        #(20 * 20000);
        mismatches++;
        complete_run();
    end
    initial
    begin
        repeat (16) @(negedge clock);
        `CHK("reset", 8'h20, status)
        rst_n = 1'b1;
        transcoder_enable = 1'b1;
        repeat (3) @(negedge clock);
        `CHK("tc_between", 1'b0, transcoder_active_q)
        frame();
        `CHK("tc_on", 1'b1, transcoder_active_q)
        transcoder_enable = 1'b0;
        frame();
        `CHK("tc_off", 1'b0, transcoder_active_q)
        // a buffer enable without io power must stay idle
        port_buffer_enable = 1'b1;
        io_power_request   = 1'b1;
        repeat (50) @(negedge clock);
        io_power_request = 1'b0;
        repeat (150) @(negedge clock);
        `CHK("io_short", 2'h1, ({io_power_enabled_q, port_buffer_idle_q}))
        port_buffer_enable = 1'b0;
        io_power_request   = 1'b1;
        for (n = 0; io_power_enabled_q !== 1'b1 && n < 2000; n++) @(negedge clock);
        `CHK("io_time", 1'b1, n <= 1000)
        port_buffer_enable = 1'b1;
        for (n = 0; port_buffer_idle_q !== 1'b0 && n < 26000; n++) @(negedge clock);
        `CHK("buf_wake", 1'b1, n <= 25000)
        for (int i = 0; i < 5; i++)
        begin
            {link_training_enable, link_training_select, vga_plane_active} = row_in[i][4:1];
            vga_clocking_mode_register = row_in[i][0] ? 8'h20 : 8'hdf;
            repeat (2) @(negedge clock);
            `CHK("row", row_out[i], ({lane_symbol_kind_q, vga_screen_blank_q}))
        end
        {link_training_enable, link_training_select} = 3'h5;
        for (n = 0; min_idles_sent_q !== 1'b1 && n < 100; n++) @(negedge clock);
        `CHK("idles", 1'b1, n >= 16 && n < 100)
        link_training_select = `DPMS_TP_NORMAL;
        fec_enable           = 1'b1;
        repeat (3) @(negedge clock);
        `CHK("idles_clr", 2'h1, ({min_idles_sent_q, fec_active_q}))
        port_buffer_enable = 1'b0;
        for (n = 0; port_buffer_idle_q !== 1'b1 && n < 1000; n++) @(negedge clock);
        `CHK("buf_drain", 2'h2, ({n <= 400, fec_active_q}))
        io_power_request = 1'b0;
        repeat (2) @(negedge clock);
        `CHK("io_off", 1'b0, io_power_enabled_q)
        // reset in mid-run with the transcoder running and blanking requested
        transcoder_enable = 1'b1;
        frame();
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        `CHK("reset_mid", 8'h20, status)
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        `CHK("reset_rel", 2'h1, ({transcoder_active_q, vga_screen_blank_q}))
        complete_run();
    end
endmodule // dpms_port_ctrl_tb

//--- sim/dpms_sink_model.sv
// behavioural display sink: reports idle patterns seen on the lanes
`include "dpms_defs.vh"
module dpms_sink_model
#(
    parameter int IDLE_GAP = 4
)
(
    // clock
    input  logic       clock,
    // link side
    input  logic [1:0] lane_symbol_kind_q,
    output logic       idle_pattern_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    int gap = 0;
    initial idle_pattern_tick = 1'b0;
    // the tick stands still unless idle symbols are on the lanes
    always @(posedge clock)
    begin
        idle_pattern_tick <= 1'b0;
        if (lane_symbol_kind_q != `DPMS_SYM_IDLE)
            gap <= 0;
        else if (gap == IDLE_GAP - 1)
        begin
            gap               <= 0;
            idle_pattern_tick <= 1'b1;
        end
        else
            gap <= gap + 1;
    end
endmodule // dpms_sink_model
